// File: hw/dpw_top.sv
// Wiper control top: serial slave on SCL, registers on system clock
`timescale 1ns/10ps
module dpw_top
  import dpw_pkg::*;
#(
  parameter int         WRITE_CYC = NV_WRITE_CYC,
  parameter logic [4:0] DEV_ID    = DEV_ID_DFLT
) (
  // System clock and power-up reset
  input  wire logic            mclk_in,
  input  wire logic            rst_in,
  // Serial link
  input  wire logic            scl_in,
  input  wire logic            sda_in,
  output logic                 sda_out,
  output logic                 sda_oe_out,
  // Straps and shutdown pin
  input  wire logic            addr_strap_hi_in,
  input  wire logic            addr_strap_lo_in,
  input  wire logic            power_down_low_in,
  // Resistor array
  output logic [TAPS-1:0]      tap_en_out,
  output logic                 wiper_gnd_out,
  output logic                 array_open_out,
  output logic                 nv_write_pending_out
);
  function automatic logic [7:0] rd_byte(input logic [7:0] addr, input dpw_snap_t s);
    rd_byte = 8'h00;
    if (addr == REG_WIPER) begin
      rd_byte = s.access_control_reg[ACR_VOL_BIT] ? {1'b0, s.wiper} : {1'b0, s.initial_value_store}; // see RL16 RL19
    end else if (addr == REG_ACR) begin
      rd_byte = s.access_control_reg;
    end
  endfunction

  // ---------------------------------------------
  // SDA edge toggles for START and STOP
  // ---------------------------------------------
  // Clocked by SDA itself; no reset is possible here
  logic start_tog_r = 1'b0;
  logic stop_tog_r  = 1'b0;

  always_ff @(negedge sda_in) begin
    if (scl_in) begin
      start_tog_r <= ~start_tog_r;
    end
  end

  always_ff @(posedge sda_in) begin
    if (scl_in) begin
      stop_tog_r <= ~stop_tog_r;
    end
  end

  // ---------------------------------------------
  // Link domain synchronisers
  // ---------------------------------------------
  logic       lrst_meta_r;
  logic       lrst_r;
  logic [1:0] strap_meta_r;
  logic [1:0] strap_r;
  dpw_snap_t  snap_meta_r;
  dpw_snap_t  snap_sync_r;
  dpw_snap_t  snap_r;

  always_ff @(posedge scl_in) begin
    lrst_meta_r  <= rst_in;
    lrst_r       <= lrst_meta_r;
    strap_meta_r <= {addr_strap_hi_in, addr_strap_lo_in};
    strap_r      <= strap_meta_r;
    snap_meta_r  <= snap_r;
    snap_sync_r  <= snap_meta_r;
  end

  // ---------------------------------------------
  // Link byte engine
  // ---------------------------------------------
  dpw_lnk_t   st_r;
  dpw_lnk_t   st_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic       ack_r;
  logic       ack_nxt;
  logic       start_ack_r;
  dpw_wreq_t  wreq_r;
  dpw_wreq_t  wreq_nxt;
  logic       wtog_r;
  logic       wtog_nxt;
  logic       start_seen;
  logic [7:0] rx_byte;

  // START hold and SCL low time settle the toggle before the next rise
  assign start_seen = start_tog_r ^ start_ack_r;
  assign rx_byte    = {sh_r[6:0], sda_in}; // see RL11

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    tx_nxt   = tx_r;
    addr_nxt = addr_r;
    ack_nxt  = ack_r;
    wreq_nxt = wreq_r;
    wtog_nxt = wtog_r;
    if (start_seen) begin
      st_nxt  = LNK_DEV;
      cnt_nxt = 4'h1;
      sh_nxt  = {7'h00, sda_in};
      ack_nxt = 1'b0;
    end else if (st_r != LNK_IDLE) begin
      if (cnt_r < 4'h7) begin
        sh_nxt  = rx_byte;
        cnt_nxt = cnt_r + 4'h1;
      end else if (cnt_r == 4'h7) begin
        cnt_nxt = 4'h8;
        ack_nxt = 1'b0;
        unique case (st_r)
          LNK_IDLE: begin
          end
          LNK_DEV: begin
            if (rx_byte[7:3] == DEV_ID && rx_byte[2:1] == strap_r) begin // see RL12 RL13
              ack_nxt = 1'b1;
              if (rx_byte[0]) begin
                // First byte loads on our own ACK bit, below
                st_nxt = LNK_RDAT;
              end else begin
                st_nxt = LNK_REG;
              end
            end else begin
              st_nxt = LNK_IDLE; // see RL21
            end
          end
          LNK_REG: begin
            addr_nxt = rx_byte;
            ack_nxt  = 1'b1;
            st_nxt   = LNK_WDAT;
          end
          LNK_WDAT: begin
            wreq_nxt = '{addr: addr_r, data: rx_byte};
            wtog_nxt = ~wtog_r;
            addr_nxt = addr_r + 8'h01;
            ack_nxt  = 1'b1;
          end
          LNK_RDAT: begin
          end
        endcase
      end else begin
        cnt_nxt = 4'h0;
        if (st_r == LNK_RDAT) begin
          if (sda_in) begin
            st_nxt = LNK_IDLE;
          end else begin
            tx_nxt   = rd_byte(addr_r, snap_sync_r); // see RL16
            addr_nxt = addr_r + 8'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge scl_in) begin
    start_ack_r <= start_tog_r;
    if (lrst_r) begin
      st_r   <= LNK_IDLE;
      cnt_r  <= 4'h0;
      sh_r   <= 8'h00;
      tx_r   <= 8'h00;
      addr_r <= 8'h00;
      ack_r  <= 1'b0;
      wreq_r <= '0;
      wtog_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      sh_r   <= sh_nxt;
      tx_r   <= tx_nxt;
      addr_r <= addr_nxt;
      ack_r  <= ack_nxt;
      wreq_r <= wreq_nxt;
      wtog_r <= wtog_nxt;
    end
  end

  // ---------------------------------------------
  // SDA driver on falling SCL
  // ---------------------------------------------
  logic oe_r;
  logic oe_nxt;
  logic tx_bit;

  assign tx_bit = tx_r[3'(4'h7 - cnt_r)];

  always_comb begin
    oe_nxt = 1'b0;
    if (st_r == LNK_RDAT && cnt_r != 4'h8) begin
      oe_nxt = ~tx_bit; // see RL11
    end else if (cnt_r == 4'h8) begin
      oe_nxt = ack_r; // see RL21
    end
  end

  always_ff @(negedge scl_in) begin
    if (lrst_r) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= oe_nxt;
    end
  end

  // Open drain: the driven level is always low
  assign sda_out    = 1'b0;
  assign sda_oe_out = oe_r;

  // ---------------------------------------------
  // System clock crossings
  // ---------------------------------------------
  logic [2:0] wtog_s_r;
  logic [2:0] stog_s_r;
  logic [1:0] pd_s_r;

  always_ff @(posedge mclk_in) begin
    wtog_s_r <= {wtog_s_r[1:0], wtog_r};
    stog_s_r <= {stog_s_r[1:0], stop_tog_r};
    pd_s_r   <= {pd_s_r[0], power_down_low_in};
  end

  // ---------------------------------------------
  // Register file and recall
  // ---------------------------------------------
  logic [6:0] wr_r;
  logic [6:0] wr_nxt;
  logic       vol_r;
  logic       vol_nxt;
  logic       power_down_low_bit_r;
  logic       power_down_low_bit_nxt;
  logic       nv_pend_r;
  logic       nv_pend_nxt;
  logic [6:0] nv_data_r;
  logic [6:0] nv_data_nxt;
  logic       nv_start_r;
  logic       nv_start_nxt;
  logic [7:0] rcl_cnt_r;
  logic [7:0] rcl_cnt_nxt;
  logic       rcl_done_r;
  logic       rcl_done_nxt;
  dpw_snap_t  snap_nxt;
  logic       nv_busy;
  logic [6:0] nv_cell;
  logic       normal;
  logic       wevt;
  logic       stop_evt;

  assign wevt     = wtog_s_r[2] ^ wtog_s_r[1];
  assign stop_evt = stog_s_r[2] ^ stog_s_r[1];
  assign normal   = pd_s_r[1] & power_down_low_bit_r; // see RL9 RL17

  always_comb begin
    wr_nxt       = wr_r;
    vol_nxt      = vol_r;
    power_down_low_bit_nxt = power_down_low_bit_r;
    nv_pend_nxt  = nv_pend_r;
    nv_data_nxt  = nv_data_r;
    nv_start_nxt = 1'b0;
    rcl_cnt_nxt  = rcl_cnt_r;
    rcl_done_nxt = rcl_done_r;
    if (!rcl_done_r) begin
      if (rcl_cnt_r == 8'(RECALL_CYC - 1)) begin
        wr_nxt       = nv_cell; // see RL5
        rcl_done_nxt = 1'b1;
      end else begin
        rcl_cnt_nxt = rcl_cnt_r + 8'h01;
      end
    end else if (wevt && !nv_busy) begin // see RL18 RL10
      if (wreq_r.addr == REG_WIPER) begin
        wr_nxt = wreq_r.data[6:0]; // see RL16
        if (!vol_r) begin
          nv_pend_nxt = 1'b1; // see RL19
          nv_data_nxt = wreq_r.data[6:0];
        end
      end else if (wreq_r.addr == REG_ACR) begin
        vol_nxt      = wreq_r.data[ACR_VOL_BIT]; // see RL19
        power_down_low_bit_nxt = wreq_r.data[ACR_POWER_DOWN_LOW_BIT]; // see RL17
      end
    end
    if (stop_evt && nv_pend_nxt && !nv_busy) begin
      nv_start_nxt = 1'b1; // see RL15
      nv_pend_nxt  = 1'b0;
    end
    snap_nxt.wiper = wr_r;
    snap_nxt.initial_value_store   = nv_cell;
    snap_nxt.access_control_reg   = 8'h00;
    snap_nxt.access_control_reg[ACR_VOL_BIT]  = vol_r;
    snap_nxt.access_control_reg[ACR_POWER_DOWN_LOW_BIT] = power_down_low_bit_r;
    snap_nxt.access_control_reg[ACR_WIP_BIT]  = nv_busy | nv_pend_r | nv_start_r; // see RL18
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wr_r       <= WIPER_RST; // see RL4
      vol_r      <= VOL_RST;
      power_down_low_bit_r <= POWER_DOWN_LOW_BIT_RST;
      nv_pend_r  <= 1'b0;
      nv_data_r  <= WIPER_RST;
      nv_start_r <= 1'b0;
      rcl_cnt_r  <= 8'h00;
      rcl_done_r <= 1'b0;
      snap_r     <= '0;
    end else begin
      wr_r       <= wr_nxt;
      vol_r      <= vol_nxt;
      power_down_low_bit_r <= power_down_low_bit_nxt;
      nv_pend_r  <= nv_pend_nxt;
      nv_data_r  <= nv_data_nxt;
      nv_start_r <= nv_start_nxt;
      rcl_cnt_r  <= rcl_cnt_nxt;
      rcl_done_r <= rcl_done_nxt;
      snap_r     <= snap_nxt;
    end
  end

  // ---------------------------------------------
  // Store and switch array
  // ---------------------------------------------
  dpw_nv_store #(
    .WRITE_CYC (WRITE_CYC)
  ) u_nv (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .start_in (nv_start_r),
    .data_in  (nv_data_r),
    .busy_out (nv_busy),
    .cell_out (nv_cell)
  );

  dpw_tap_switch #(
    .OVERLAP_CYC (MBB_CYC)
  ) u_tap (
    .mclk_in        (mclk_in),
    .rst_in         (rst_in),
    .code_in        (wr_r),
    .normal_in      (normal),
    .tap_en_out     (tap_en_out),
    .wiper_gnd_out  (wiper_gnd_out),
    .array_open_out (array_open_out)
  );

  assign nv_write_pending_out = nv_busy;
endmodule

// File: pkg/dpw_pkg.sv
// Constants and types for the digital pot wiper control block
// Function
// RL1: 7-bit volatile wiper register selects the tap
// RL2: Code 00h nearest ground, 7Fh nearest supply
// RL3: Rising code moves tap monotonically toward supply
// RL4: Wiper register presets to 40h at power-up
// RL5: Recall stored initial value once supply settles
// RL6: Initial value store survives power-down
// RL7: Shutdown opens array, ties wiper to ground
// RL8: Leaving shutdown restores the unchanged wiper tap
// RL9: Normal operation is pin AND control bit
// RL10: Serial port and registers stay usable in shutdown
// RL11: Sample on SCL rise, drive after SCL fall
// RL12: Strap pins give the two address LSBs
// RL13: Respond only when address matches strap levels
// RL14: Make new tap before breaking old tap
// RL15: STOP after write starts self-timed store write
// RL16: Master reads and writes wiper and store
// RL17: Control bit 6 shutdown, default 1, 0 shuts
// RL18: Bit 5 write-pending, blocks register writes
// RL19: Bit 7 selects store or wiper at address 0
// RL20: Master waits 20 ms between store writes
// RL21: Address mismatch releases SDA until next START
package dpw_pkg;
  localparam int          CLK_MHZ       = 40;
  localparam int          NV_WRITE_MS   = 20;
  localparam int          NV_WRITE_CYC  = NV_WRITE_MS * CLK_MHZ * 1000;
  localparam int          RECALL_NS     = 1000;
  localparam int          RECALL_CYC    = (RECALL_NS * CLK_MHZ + 999) / 1000;
  localparam int          MBB_NS        = 100;
  localparam int          MBB_CYC       = (MBB_NS * CLK_MHZ + 999) / 1000;
  localparam int          WIPER_W       = 7;
  localparam int          TAPS          = 128;
  localparam logic [6:0]  WIPER_RST     = 7'h40;
  localparam logic [6:0]  IVR_INIT      = 7'h40;
  localparam logic [7:0]  REG_WIPER     = 8'h00;
  localparam logic [7:0]  REG_ACR       = 8'h02;
  localparam int          ACR_VOL_BIT   = 7;
  localparam int          ACR_POWER_DOWN_LOW_BIT  = 6;
  localparam int          ACR_WIP_BIT   = 5;
  localparam logic        VOL_RST       = 1'b0;
  localparam logic        POWER_DOWN_LOW_BIT_RST  = 1'b1;
  // Arbitrary value, not tied to any maker
  localparam logic [4:0]  DEV_ID_DFLT   = 5'h0C;

  typedef enum logic [4:0] {
    LNK_IDLE = 5'h01,
    LNK_DEV  = 5'h02,
    LNK_REG  = 5'h04,
    LNK_WDAT = 5'h08,
    LNK_RDAT = 5'h10
  } dpw_lnk_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } dpw_wreq_t;

  typedef struct packed {
    logic [6:0] wiper;
    logic [6:0] initial_value_store;
    logic [7:0] access_control_reg;
  } dpw_snap_t;
endpackage

// File: hw/dpw_nv_store.sv
// Non-volatile initial value store with self-timed write cycle
`timescale 1ns/10ps
module dpw_nv_store
  import dpw_pkg::*;
#(
  parameter int WRITE_CYC = NV_WRITE_CYC
) (
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         rst_in,
  // Write request
  input  wire logic         start_in,
  input  wire logic [6:0]   data_in,
  // State
  output logic              busy_out,
  output logic [6:0]        cell_out
);
  // ---------------------------------------------
  // Cell and write timer
  // ---------------------------------------------
  // Cell has no reset so it survives power-down
  logic [6:0]  cell_r = IVR_INIT;
  logic [6:0]  cell_nxt;
  logic [6:0]  data_r;
  logic [6:0]  data_nxt;
  logic        busy_r;
  logic        busy_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;

  always_comb begin
    cell_nxt = cell_r;
    data_nxt = data_r;
    busy_nxt = busy_r;
    cnt_nxt  = cnt_r;
    if (busy_r) begin
      if (cnt_r == 32'(WRITE_CYC - 1)) begin
        busy_nxt = 1'b0;
        cell_nxt = data_r; // see RL6
      end else begin
        cnt_nxt = cnt_r + 32'h00000001; // see RL15
      end
    end else if (start_in) begin
      busy_nxt = 1'b1;
      data_nxt = data_in;
      cnt_nxt  = 32'h00000000;
    end
  end

  always_ff @(posedge mclk_in) begin
    cell_r <= cell_nxt;
    data_r <= data_nxt;
    if (rst_in) begin
      busy_r <= 1'b0;
      cnt_r  <= 32'h00000000;
    end else begin
      busy_r <= busy_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  assign busy_out = busy_r;
  assign cell_out = cell_r;
endmodule

// File: hw/dpw_tap_switch.sv
// Tap switch driver with make-before-break and shutdown
`timescale 1ns/10ps
module dpw_tap_switch
  import dpw_pkg::*;
#(
  parameter int OVERLAP_CYC = MBB_CYC
) (
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  // Control
  input  wire logic [6:0]        code_in,
  input  wire logic              normal_in,
  // Array switches
  output logic [TAPS-1:0]        tap_en_out,
  output logic                   wiper_gnd_out,
  output logic                   array_open_out
);
  function automatic logic [TAPS-1:0] onehot(input logic [6:0] code);
    onehot = '0;
    onehot[code] = 1'b1;
  endfunction

  // ---------------------------------------------
  // Tap state
  // ---------------------------------------------
  logic [6:0]      cur_r;
  logic [6:0]      cur_nxt;
  logic [6:0]      old_r;
  logic [6:0]      old_nxt;
  logic [7:0]      ovl_r;
  logic [7:0]      ovl_nxt;
  logic [TAPS-1:0] en_r;
  logic [TAPS-1:0] en_nxt;
  logic            gnd_r;
  logic            gnd_nxt;

  always_comb begin
    cur_nxt = code_in;
    old_nxt = old_r;
    ovl_nxt = ovl_r;
    if (code_in != cur_r) begin
      old_nxt = cur_r;
      ovl_nxt = 8'(OVERLAP_CYC); // see RL14
    end else if (ovl_r != 8'h00) begin
      ovl_nxt = ovl_r - 8'h01;
    end
    // Tap index is the code itself, so order is monotonic
    en_nxt = onehot(cur_nxt); // see RL1 RL2 RL3
    if (ovl_nxt != 8'h00) begin
      en_nxt = en_nxt | onehot(old_nxt); // see RL14
    end
    gnd_nxt = ~normal_in;
    if (!normal_in) begin
      en_nxt = '0; // see RL7 RL8
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cur_r <= WIPER_RST;
      old_r <= WIPER_RST;
      ovl_r <= 8'h00;
      en_r  <= onehot(WIPER_RST);
      gnd_r <= 1'b0;
    end else begin
      cur_r <= cur_nxt;
      old_r <= old_nxt;
      ovl_r <= ovl_nxt;
      en_r  <= en_nxt;
      gnd_r <= gnd_nxt;
    end
  end

  assign tap_en_out     = en_r;
  assign wiper_gnd_out  = gnd_r;
  assign array_open_out = gnd_r;
endmodule

// File: verif/dpw_i2c_master.sv
// Behavioural serial bus master driving the wiper control block
`timescale 1ns/10ps
module dpw_i2c_master (
  // Bus pins
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      pull_out
);
  // ----------------------------------------
  // Bit engine, 15 ns bit time
  // ----------------------------------------
  // Clock parks high between frames, data released
  initial begin
    scl_out = 1'b1;
    pull_out = 1'b0;
  end

  // Data moves in the low phase, read at the rise
  task automatic bit_x(input logic b, output logic r);
    #3 pull_out = ~b;
    #4.5 scl_out = 1'b1;
    r = sda_in;
    #7.5 scl_out = 1'b0;
  endtask

  // Also serves as repeated start
  task automatic start();
    #3 pull_out = 1'b0;
    #3 scl_out = 1'b1;
    #4 pull_out = 1'b1;
    #4 scl_out = 1'b0;
  endtask

  task automatic stop();
    #3 pull_out = 1'b1;
    #3 scl_out = 1'b1;
    #4 pull_out = 1'b0;
  endtask

  // Clock pulses with data released; the link reset needs them
  task automatic idle_clk(input int n);
    repeat (n) begin
      #7.5 scl_out = 1'b0;
      #7.5 scl_out = 1'b1;
    end
  endtask

  // Eight bits MSB first, then the ninth
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ack_in, ack);
  endtask
endmodule

// File: verif/dpw_top_props.sv
// Concurrent checks on the wiper control top ports
`timescale 1ns/10ps
module dpw_top_props
  import dpw_pkg::*;
#(
  parameter int WRITE_CYC = NV_WRITE_CYC
) (
  // Clocks and reset
  input wire logic            mclk_in,
  input wire logic            rst_in,
  input wire logic            scl_in,
  // Observed pins
  input wire logic            power_down_low_in,
  input wire logic            sda_oe_out,
  input wire logic [TAPS-1:0] tap_en_out,
  input wire logic            wiper_gnd_out,
  input wire logic            array_open_out,
  input wire logic            nv_write_pending_out
);
  // ----------------------------------------
  // Store write length counter
  // ----------------------------------------
  logic [31:0] wip_cnt_r;
  logic [31:0] wip_cnt_nxt;
  always_comb begin
    wip_cnt_nxt = nv_write_pending_out ? wip_cnt_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge mclk_in) begin
    wip_cnt_r <= rst_in ? 32'h0 : wip_cnt_nxt;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_tap_onehot :
    assert property (@(posedge mclk_in) disable iff (rst_in)
      !array_open_out |-> $countones(tap_en_out) inside {1, 2}) else $error("tap enables not one or two hot");
  chk_make_break :
    assert property (@(posedge mclk_in) disable iff (rst_in)
      !array_open_out && !$past(array_open_out) && !$past(array_open_out, 2)
      |-> |(tap_en_out & $past(tap_en_out))) else $error("old tap dropped before new tap made");
  chk_overlap_len :
    assert property (@(posedge mclk_in) disable iff (rst_in)
      $rose($countones(tap_en_out) == 2) |-> ($countones(tap_en_out) == 2) [*3] ##[1:4]
      ($countones(tap_en_out) == 1)) else $error("tap overlap length wrong");
  chk_gnd_open :
    assert property (@(posedge mclk_in) disable iff (rst_in)
      wiper_gnd_out == array_open_out) else $error("ground tie and array open differ");
  chk_pin_shut :
    assert property (@(posedge mclk_in) disable iff (rst_in)
      !power_down_low_in [*5] |-> wiper_gnd_out) else $error("shutdown pin ignored");
  chk_wip_len :
    assert property (@(posedge mclk_in) disable iff (rst_in)
      $fell(nv_write_pending_out) |-> wip_cnt_r >= WRITE_CYC && wip_cnt_r <= WRITE_CYC + 8)
      else $error("store write length wrong");
  chk_wip_hold :
    assert property (@(posedge mclk_in) disable iff (rst_in)
      nv_write_pending_out [*8] |-> $stable({tap_en_out, array_open_out})) else $error("write taken while busy");
  chk_oe_scl :
    assert property (@(edge scl_in) disable iff (rst_in)
      scl_in && !$past(scl_in) |-> $stable(sda_oe_out)) else $error("data pin moved while clock high");

  cover property (@(posedge mclk_in) $rose(nv_write_pending_out));
  cover property (@(posedge mclk_in) $rose(array_open_out));
  cover property (@(posedge mclk_in) $rose($countones(tap_en_out) == 2));
endmodule

// File: verif/dpw_top_tb_top.sv
// Self-checking bench for the wiper control block
`timescale 1ns/10ps
module dpw_top_tb_top
  import dpw_pkg::*;
;
  localparam int WCYC = 200;
  logic         mclk = 1'b0;
  logic         rst = 1'b1;
  logic         s_hi = 1'b0;
  logic         s_lo = 1'b0;
  logic         pdown_low = 1'b1;
  logic         scl, pull, sda_oe, gnd, opn, pend, ack;
  logic         sda_w;
  logic [127:0] tap, seen;
  logic [7:0]   q;
  logic [6:0]   id;
  logic [127:0] exp_q[$];
  string        nam_q[$];
  event         seen_ev;
  int           errors = 0;
  int           checks_done = 0;
  int           cyc = 0;

  always #12.5 mclk = ~mclk;
  // Pull-up: low whenever either side pulls
  assign sda_w = ~(pull | sda_oe);
  assign id = {DEV_ID_DFLT, s_hi, s_lo};

  dpw_top #(.WRITE_CYC(WCYC)) DUT (.mclk_in(mclk), .rst_in(rst), .scl_in(scl), .sda_in(sda_w), .sda_out(),
    .sda_oe_out(sda_oe), .addr_strap_hi_in(s_hi), .addr_strap_lo_in(s_lo), .power_down_low_in(pdown_low),
    .tap_en_out(tap), .wiper_gnd_out(gnd), .array_open_out(opn), .nv_write_pending_out(pend));
  dpw_i2c_master BFM (.sda_in(sda_w), .scl_out(scl), .pull_out(pull));

  // ----------------------------------------
  // Scoreboard and closing
  // ----------------------------------------
  always @(seen_ev) begin
    checks_done++;
    if (seen !== exp_q[0]) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", nam_q[0], exp_q[0], seen);
    end
    void'(exp_q.pop_front());
    void'(nam_q.pop_front());
  end

  task automatic note(input string n, input logic [127:0] e, input logic [127:0] g);
    exp_q.push_back(e);
    nam_q.push_back(n);
    seen = g;
    ->seen_ev;
    #1;
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Register access over the serial link
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    BFM.start();
    BFM.xfer({id, 1'b0}, 1'b1, q, ack);
    BFM.xfer(a, 1'b1, q, ack);
    BFM.xfer(d, 1'b1, q, ack);
    BFM.stop();
    repeat (12) @(posedge mclk);
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    BFM.start();
    BFM.xfer({id, 1'b0}, 1'b1, q, ack);
    BFM.xfer(a, 1'b1, q, ack);
    BFM.start();
    BFM.xfer({id, 1'b1}, 1'b1, q, ack);
    BFM.xfer(8'hFF, 1'b1, d, ack);
    BFM.stop();
    repeat (4) @(posedge mclk);
    note(n, 128'(e), 128'(d));
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    // Link logic only sees reset on SCL edges
    fork
      BFM.idle_clk(4);
    join_none
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    note("tap in reset", 128'h1 << WIPER_RST, tap);
    BFM.idle_clk(4);
    // Leaves time for the power-up recall
    repeat (100) @(posedge mclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [6:0] v, n;
    void'($urandom(7870));
    do_reset();
    rchk("acr", REG_ACR, 8'h40);
    rchk("store", REG_WIPER, 8'h40);
    rchk("reserved", 8'h01, 8'h00);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      {s_hi, s_lo} <= s[1:0];
      repeat (2) @(posedge mclk);
      BFM.start();
      BFM.xfer({DEV_ID_DFLT, s[1:0], 1'b0}, 1'b1, q, ack);
      BFM.stop();
      note("id ack", 128'h0, 128'(ack));
      BFM.start();
      BFM.xfer({DEV_ID_DFLT, ~s[1:0], 1'b0}, 1'b1, q, ack);
      note("id nack", 128'h1, 128'(ack));
      BFM.xfer(8'h00, 1'b1, q, ack);
      BFM.stop();
      note("idle after nack", 128'h1, 128'(ack));
      @(posedge mclk);
    end
    $display("test straps done");
    wr(REG_ACR, 8'hC0);
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 7'h00 : (k == 1) ? 7'h7F : 7'($urandom);
      wr(REG_WIPER, {1'b0, v});
      note("tap", 128'h1 << v, tap);
      rchk("wiper", REG_WIPER, {1'b0, v});
    end
    $display("test wiper done");
    pdown_low <= 1'b0;
    repeat (8) @(posedge mclk);
    note("pin shutdown", 128'h3, 128'({opn, gnd}));
    rchk("wiper in shutdown", REG_WIPER, {1'b0, v});
    pdown_low <= 1'b1;
    repeat (12) @(posedge mclk);
    note("tap restored", 128'h1 << v, tap);
    wr(REG_ACR, 8'h80);
    note("bit shutdown", 128'h3, 128'({opn, gnd}));
    rchk("acr in shutdown", REG_ACR, 8'h80);
    wr(REG_ACR, 8'hC0);
    note("tap after bit", 128'h1 << v, tap);
    $display("test shutdown done");
    n = 7'($urandom);
    wr(REG_ACR, 8'h40);
    wr(REG_WIPER, {1'b0, n});
    note("tap from store write", 128'h1 << n, tap);
    note("pending", 128'h1, 128'(pend));
    rchk("acr busy", REG_ACR, 8'h60);
    wr(REG_ACR, 8'hC0);
    for (int i = 0; i < 1000 && pend !== 1'b0; i++) @(posedge mclk);
    rchk("acr kept", REG_ACR, 8'h40);
    rchk("store value", REG_WIPER, {1'b0, n});
    $display("test store write done");
    do_reset();
    note("tap recalled", 128'h1 << n, tap);
    rchk("store kept", REG_WIPER, {1'b0, n});
    $display("test recall done");
    end_of_test();
  end
endmodule

bind dpw_top dpw_top_props #(.WRITE_CYC(WRITE_CYC)) u_props (.mclk_in(mclk_in), .rst_in(rst_in),
  .scl_in(scl_in), .power_down_low_in(power_down_low_in), .sda_oe_out(sda_oe_out), .tap_en_out(tap_en_out),
  .wiper_gnd_out(wiper_gnd_out), .array_open_out(array_open_out), .nv_write_pending_out(nv_write_pending_out));
